// [vocs_pkg.sv]
// Shared constants for the video output configuration and scale block
package vocs_pkg;

   // Register select codes on the core's special register port
   localparam logic REG_SEL_CONFIG = 1'h0; // Video configuration register
   localparam logic REG_SEL_SCALE = 1'h1; // Video scale register

   // Configuration field positions
   localparam int CFG_MASK_LSB = 0; // Output pin mask, 8 bits
   localparam int CFG_MASK_W = 8;
   localparam int CFG_GROUP_LSB = 9; // Output group select, 3 bits
   localparam int CFG_GROUP_W = 3;
   localparam int CFG_AURAL_LSB = 23; // Aural sub-carrier source, stored only
   localparam int CFG_AURAL_W = 3;
   localparam int CFG_CHROMA0_BIT = 26; // Baseband chroma enable, stored only
   localparam int CFG_CHROMA1_BIT = 27; // Broadcast chroma enable, stored only
   localparam int CFG_DEPTH_BIT = 28; // Colour depth select
   localparam int CFG_TYPE_LSB = 29; // Output type select, 2 bits
   localparam int CFG_TYPE_W = 2;

   // Bits of the configuration word that hold state; the rest read zero
   localparam logic [31:0] CFG_STORED_MASK = 32'h7F800EFF;
   localparam logic [31:0] CFG_RESET = 32'h00000000;

   // Scale field positions
   localparam int SCL_FRAME_LSB = 0; // Per-frame period, 12 bits
   localparam int SCL_FRAME_W = 12;
   localparam int SCL_PIXEL_LSB = 12; // Per-pixel period, 8 bits
   localparam int SCL_PIXEL_W = 8;
   localparam logic [31:0] SCL_STORED_MASK = 32'h000FFFFF;
   localparam logic [31:0] SCL_RESET = 32'h00000000;

   // Output type select codes
   localparam logic [1:0] TYPE_OFF = 2'h0;
   localparam logic [1:0] TYPE_PARALLEL = 2'h1;
   localparam logic [1:0] TYPE_COMPOSITE1 = 2'h2;
   localparam logic [1:0] TYPE_COMPOSITE2 = 2'h3;

   // Output group select codes; anything above the last is reserved
   localparam logic [2:0] GROUP_LAST = 3'h3;

   // Handoff word: colours in the upper half, pixels in the lower half
   localparam int HANDOFF_W = 64;
   localparam int BUF_DEPTH = 2;

   // Generator states
   typedef enum logic [0:0]
   {
      VOCS_IDLE = 1'b0,
      VOCS_RUN = 1'b1
   } vocs_state_t;

endpackage

// [vocs_buffer.sv]
// Two-entry handoff buffer between the owning core and the video generator
module vocs_buffer
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [vocs_pkg::HANDOFF_W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   input wire logic out_ready,
   output logic [vocs_pkg::HANDOFF_W-1:0] out_data
);

   logic [vocs_pkg::HANDOFF_W-1:0] mem_q [vocs_pkg::BUF_DEPTH]; // Storage entries
   logic [vocs_pkg::HANDOFF_W-1:0] mem_d [vocs_pkg::BUF_DEPTH];
   logic wr_q, wr_d; // Write index
   logic rd_q, rd_d; // Read index
   logic [1:0] cnt_q, cnt_d; // Entries held
   logic rdy_q, rdy_d; // Registered space flag
   logic push, pop;

   // Next state; ready is registered so the core sees a clean stall
   always_comb
   begin
      push = in_valid && rdy_q;
      pop = (cnt_q != 2'h0) && out_ready;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wr_q] = in_data;
         wr_d = ~wr_q;
      end
      if (pop)
      begin
         rd_d = ~rd_q;
      end
      if (push && !pop)
      begin
         cnt_d = cnt_q + 2'h1;
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - 2'h1;
      end
      rdy_d = (cnt_d != 2'h2);
   end

   // Register update
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
         rdy_q <= 1'b0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
      end
      mem_q <= mem_d;
   end

   assign in_ready = rdy_q;
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];

endmodule // vocs_buffer

// [vocs_video_gen.sv]
// Per-core video generator with configuration and scale registers
module vocs_video_gen
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic SYNTH_CLOCK_A,
   input wire logic REG_SEL,
   input wire logic REG_WR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   input wire logic HANDOFF_VALID,
   input wire logic [31:0] HANDOFF_COLOURS,
   input wire logic [31:0] HANDOFF_PIXELS,
   output logic HANDOFF_READY,
   output logic [31:0] VIDEO_OUT,
   output logic [31:0] VIDEO_OE
);

   // Place a byte into the selected group of the 32-pin port; reserved groups drive nothing
   function automatic logic [31:0] place_byte(input logic [2:0] grp, input logic [7:0] b);
      logic [31:0] w;
      w = 32'h00000000;
      if (grp <= vocs_pkg::GROUP_LAST)
      begin
         w = {24'h000000, b} << {grp[1:0], 3'h0};
      end
      return w;
   endfunction

   // Pick the colour byte chosen by a pixel index
   function automatic logic [7:0] pick_colour(input logic [31:0] cols, input logic [1:0] idx);
      logic [7:0] c;
      c = cols[{idx, 3'h0} +: 8];
      return c;
   endfunction

   // Register file
   logic [31:0] cfg_q, cfg_d; // Video configuration
   logic [31:0] scl_q, scl_d; // Video scale
   logic [31:0] rdata_q, rdata_d; // Read data

   // Synthesized clock sampler: three stages, edge counted once stages two and three agree
   logic sa1_q, sa2_q, sa3_q;
   logic sa_lvl_q, sa_lvl_d;
   logic tick; // One system cycle per synthesized rising edge

   // Generator state
   vocs_pkg::vocs_state_t st_q, st_d;
   logic [7:0] pix_cnt_q, pix_cnt_d; // Clocks left in this pixel
   logic [11:0] frm_cnt_q, frm_cnt_d; // Clocks left in this frame
   logic [7:0] pix_per_q, pix_per_d; // Pixel period latched at frame start
   logic [31:0] shift_q, shift_d; // Pixel shifter
   logic [31:0] cols_q, cols_d; // Colour word of current frame
   logic [31:0] vout_q, vout_d;
   logic [31:0] voe_q, voe_d;

   // Buffer hookup
   logic buf_valid, buf_pop;
   logic [vocs_pkg::HANDOFF_W-1:0] buf_data;

   // Configuration decode
   logic [1:0] out_type;
   logic depth4;
   logic [2:0] grp;
   logic [7:0] mask;
   logic [7:0] pix_per_cfg;
   logic [11:0] frm_per_cfg;
   logic [7:0] colour;
   logic [7:0] drive_byte;

   // The core stalls here while both entries are full, so no word is lost
   vocs_buffer u_buf
   (
      .clk(CLK),
      .rst(RST),
      .in_valid(HANDOFF_VALID),
      .in_data({HANDOFF_COLOURS, HANDOFF_PIXELS}),
      .in_ready(HANDOFF_READY),
      .out_valid(buf_valid),
      .out_ready(buf_pop),
      .out_data(buf_data)
   );

   // Register access: writes store only defined bits, reads return current contents
   always_comb
   begin
      cfg_d = cfg_q;
      scl_d = scl_q;
      if (REG_WR && REG_SEL == vocs_pkg::REG_SEL_CONFIG)
      begin
         cfg_d = REG_WDATA & vocs_pkg::CFG_STORED_MASK;
      end
      else if (REG_WR && REG_SEL == vocs_pkg::REG_SEL_SCALE)
      begin
         scl_d = REG_WDATA & vocs_pkg::SCL_STORED_MASK;
      end
      if (REG_SEL == vocs_pkg::REG_SEL_CONFIG)
      begin
         rdata_d = cfg_q;
      end
      else
      begin
         rdata_d = scl_q;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         cfg_q <= vocs_pkg::CFG_RESET;
         scl_q <= vocs_pkg::SCL_RESET;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         cfg_q <= cfg_d;
         scl_q <= scl_d;
         rdata_q <= rdata_d;
      end
   end

   // Edge detect on the filtered synthesized clock; the first stage feeds only the second
   always_comb
   begin
      // Level follows stage three only once stages two and three agree
      sa_lvl_d = (sa2_q == sa3_q) ? sa3_q : sa_lvl_q;
      tick = sa_lvl_d && !sa_lvl_q;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sa1_q <= 1'b0;
         sa2_q <= 1'b0;
         sa3_q <= 1'b0;
         sa_lvl_q <= 1'b0;
      end
      else
      begin
         sa1_q <= SYNTH_CLOCK_A;
         sa2_q <= sa1_q;
         sa3_q <= sa2_q;
         sa_lvl_q <= sa_lvl_d;
      end
   end

   // Field extraction
   assign out_type = cfg_q[vocs_pkg::CFG_TYPE_LSB +: vocs_pkg::CFG_TYPE_W];
   assign depth4 = cfg_q[vocs_pkg::CFG_DEPTH_BIT];
   assign grp = cfg_q[vocs_pkg::CFG_GROUP_LSB +: vocs_pkg::CFG_GROUP_W];
   assign mask = cfg_q[vocs_pkg::CFG_MASK_LSB +: vocs_pkg::CFG_MASK_W];
   assign pix_per_cfg = scl_q[vocs_pkg::SCL_PIXEL_LSB +: vocs_pkg::SCL_PIXEL_W];
   assign frm_per_cfg = scl_q[vocs_pkg::SCL_FRAME_LSB +: vocs_pkg::SCL_FRAME_W];

   // Pixel generator: counts synthesized clocks, a period of zero behaves as one
   always_comb
   begin
      st_d = st_q;
      pix_cnt_d = pix_cnt_q;
      frm_cnt_d = frm_cnt_q;
      pix_per_d = pix_per_q;
      shift_d = shift_q;
      cols_d = cols_q;
      buf_pop = 1'b0;
      if (tick)
      begin
         // Frame boundary: idle or last clock of the frame
         if (st_q == vocs_pkg::VOCS_IDLE || frm_cnt_q <= 12'h001)
         begin
            if (buf_valid)
            begin
               buf_pop = 1'b1;
               cols_d = buf_data[63:32];
               shift_d = buf_data[31:0];
               pix_cnt_d = pix_per_cfg;
               frm_cnt_d = frm_per_cfg;
               pix_per_d = pix_per_cfg;
               st_d = vocs_pkg::VOCS_RUN;
            end
            else
            begin
               // Underrun: hold colour zero until a word arrives
               st_d = vocs_pkg::VOCS_IDLE;
               shift_d = 32'h00000000;
            end
         end
         else
         begin
            frm_cnt_d = frm_cnt_q - 12'h001;
            if (pix_cnt_q <= 8'h01)
            begin
               // Next pixel each pixel period: rate is synth clock over period
               pix_cnt_d = pix_per_q;
               shift_d = depth4 ? {2'h0, shift_q[31:2]} : {1'h0, shift_q[31:1]};
            end
            else
            begin
               pix_cnt_d = pix_cnt_q - 8'h01;
            end
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         st_q <= vocs_pkg::VOCS_IDLE;
         pix_cnt_q <= 8'h00;
         frm_cnt_q <= 12'h000;
         pix_per_q <= 8'h00;
         shift_q <= 32'h00000000;
         cols_q <= 32'h00000000;
      end
      else
      begin
         st_q <= st_d;
         pix_cnt_q <= pix_cnt_d;
         frm_cnt_q <= frm_cnt_d;
         pix_per_q <= pix_per_d;
         shift_q <= shift_d;
         cols_q <= cols_d;
      end
   end

   // Pin drive: colour chosen by depth, arranged by type, gated by mask, placed in group
   always_comb
   begin
      colour = pick_colour(cols_q, depth4 ? shift_q[1:0] : {1'b0, shift_q[0]});
      // Composite encoding is outside this block; the halves carry the raw nibbles
      case (out_type)
         vocs_pkg::TYPE_PARALLEL: drive_byte = colour;
         vocs_pkg::TYPE_COMPOSITE1: drive_byte = colour;
         vocs_pkg::TYPE_COMPOSITE2: drive_byte = {colour[3:0], colour[7:4]};
         default: drive_byte = 8'h00;
      endcase
      if (out_type == vocs_pkg::TYPE_OFF)
      begin
         voe_d = 32'h00000000;
         vout_d = 32'h00000000;
      end
      else
      begin
         voe_d = place_byte(grp, mask);
         vout_d = place_byte(grp, drive_byte & mask);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         vout_q <= 32'h00000000;
         voe_q <= 32'h00000000;
      end
      else
      begin
         vout_q <= vout_d;
         voe_q <= voe_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign VIDEO_OUT = vout_q;
   assign VIDEO_OE = voe_q;

endmodule // vocs_video_gen

// [vocs_video_gen_sva.sv]
// Port-level checker for the video generator block
module vocs_checker
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic SYNTH_CLOCK_A,
   input wire logic REG_SEL,
   input wire logic REG_WR,
   input wire logic [31:0] REG_WDATA,
   input wire logic [31:0] REG_RDATA,
   input wire logic HANDOFF_VALID,
   input wire logic [31:0] HANDOFF_COLOURS,
   input wire logic [31:0] HANDOFF_PIXELS,
   input wire logic HANDOFF_READY,
   input wire logic [31:0] VIDEO_OUT,
   input wire logic [31:0] VIDEO_OE
);
   logic [31:0] cfg_q, cfg_d; // Shadow configuration
   logic [31:0] scl_q, scl_d; // Shadow of stored scale bits
   logic [3:0] cfg_age_q, cfg_age_d; // Cycles since config write
   logic [3:0] syn_age_q, syn_age_d; // Cycles since synth rise
   logic syn_prev_q, syn_prev_d; // Last synth level

   // Pins are only judged against the configuration once a config write has settled
   function automatic logic [31:0] exp_oe(input logic [31:0] c);
      if (c[30:29] == vocs_pkg::TYPE_OFF || c[11:9] > vocs_pkg::GROUP_LAST)
         return 32'h00000000;
      return {24'h000000, c[7:0]} << (8 * c[11:9]);
   endfunction

   // Next shadow state
   always_comb
   begin
      cfg_d = cfg_q;
      scl_d = scl_q;
      syn_prev_d = SYNTH_CLOCK_A;
      cfg_age_d = (cfg_age_q == 4'hF) ? cfg_age_q : cfg_age_q + 4'h1;
      syn_age_d = (syn_age_q == 4'hF) ? syn_age_q : syn_age_q + 4'h1;
      if (REG_WR && REG_SEL == vocs_pkg::REG_SEL_CONFIG)
      begin
         cfg_d = REG_WDATA;
         cfg_age_d = 4'h0;
      end
      if (REG_WR && REG_SEL == vocs_pkg::REG_SEL_SCALE)
         scl_d = REG_WDATA & vocs_pkg::SCL_STORED_MASK;
      if (SYNTH_CLOCK_A && !syn_prev_q)
         syn_age_d = 4'h0;
   end

   // Shadow registers
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         cfg_q <= 32'h00000000;
         scl_q <= 32'h00000000;
         cfg_age_q <= 4'hF;
         syn_age_q <= 4'h0;
         syn_prev_q <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;
         scl_q <= scl_d;
         cfg_age_q <= cfg_age_d;
         syn_age_q <= syn_age_d;
         syn_prev_q <= syn_prev_d;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // Config write followed by a config select
   sequence s_cfg_wr_rd;
      REG_WR && REG_SEL == vocs_pkg::REG_SEL_CONFIG ##1 REG_SEL == vocs_pkg::REG_SEL_CONFIG;
   endsequence

   a_config_read_back: assert property (s_cfg_wr_rd |=>
      REG_RDATA == ($past(REG_WDATA, 2) & vocs_pkg::CFG_STORED_MASK))
      else $error("config read back wrong");
   a_scale_read_back: assert property (!$past(RST) &&
      $past(REG_SEL) == vocs_pkg::REG_SEL_SCALE |-> REG_RDATA == $past(scl_q))
      else $error("scale read back wrong");
   a_group_pin_enable: assert property (cfg_age_q >= 4'h4 |->
      VIDEO_OE == exp_oe(cfg_q)) else $error("pin enables wrong");
   a_type_off_quiet: assert property (cfg_age_q >= 4'h4 &&
      cfg_q[30:29] == vocs_pkg::TYPE_OFF |-> VIDEO_OE == 32'h0 && VIDEO_OUT == 32'h0)
      else $error("video off yet pins active");
   a_out_within_enable: assert property ((VIDEO_OUT & ~VIDEO_OE) == 32'h0)
      else $error("video on undriven pin");
   a_ready_after_reset: assert property ($fell(RST) |=> HANDOFF_READY)
      else $error("ready missing after reset");
   a_ready_rise_cause: assert property ($rose(HANDOFF_READY) |->
      syn_age_q <= 4'h8) else $error("ready rose without frame boundary");
   a_pixel_change_cause: assert property (cfg_age_q >= 4'h4 &&
      VIDEO_OUT != $past(VIDEO_OUT) |-> syn_age_q <= 4'h8)
      else $error("pixel changed without synth edge");
endmodule // vocs_checker

bind vocs_video_gen vocs_checker chk_u (.CLK, .RST, .SYNTH_CLOCK_A, .REG_SEL, .REG_WR,
   .REG_WDATA, .REG_RDATA, .HANDOFF_VALID, .HANDOFF_COLOURS, .HANDOFF_PIXELS,
   .HANDOFF_READY, .VIDEO_OUT, .VIDEO_OE);

// [vocs_core_model.sv]
// Behavioural owning core that hands colour and pixel words over
module vocs_core_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ready,
   input wire logic [31:0] col_in,
   input wire logic [31:0] pix_in,
   input wire logic [7:0] want,
   input wire logic [7:0] gap,
   output logic valid,
   output logic [31:0] colours,
   output logic [31:0] pixels,
   output logic [7:0] taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_q; // Idle cycles before next offer

   // Offer a word, hold it until taken, then park the lines on inverted data
   always @(posedge clk)
   begin
      if (rst)
      begin
         valid <= 1'b0;
         taken <= 8'h00;
         wait_q <= 8'h00;
         colours <= 32'h00000000;
         pixels <= 32'h00000000;
      end
      else if (valid && ready)
      begin
         valid <= 1'b0;
         taken <= taken + 8'h01;
         colours <= ~colours; // Released lines must not look valid
         pixels <= ~pixels;
         wait_q <= gap;
      end
      else if (wait_q != 8'h00)
         wait_q <= wait_q - 8'h01;
      else if (!valid && taken != want) // Stays stalled while not ready
      begin
         valid <= 1'b1;
         colours <= col_in;
         pixels <= pix_in;
      end
   end
endmodule // vocs_core_model

// [vocs_video_gen_tb.sv]
// Self-checking bench for the video generator block
`define CHK(g, e) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
      end \
   end
module vocs_video_gen_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic CFG = vocs_pkg::REG_SEL_CONFIG;
   localparam logic SCL = vocs_pkg::REG_SEL_SCALE;
   localparam int SYN = 16; // Synth clock period in CLK cycles
   logic clk = 1'b0, rst = 1'b1, synth = 1'b0, synth_en = 1'b1;
   logic reg_sel = 1'b0, reg_wr = 1'b0, valid, ready;
   logic [31:0] reg_wdata = 32'h0, rdata, colours, pixels, vout, voe;
   logic [31:0] m_col = 32'h0, m_pix = 32'h0;
   logic [7:0] m_want = 8'h00, m_gap = 8'h00, m_taken;
   int n_fail = 0, check_count = 0, cyc = 0;

   always #2 clk = ~clk;
   // Synth clock; stands still while disabled
   always #32 if (synth_en) synth = ~synth;

   vocs_video_gen dut_u (.CLK(clk), .RST(rst), .SYNTH_CLOCK_A(synth), .REG_SEL(reg_sel),
      .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .HANDOFF_VALID(valid),
      .HANDOFF_COLOURS(colours), .HANDOFF_PIXELS(pixels), .HANDOFF_READY(ready),
      .VIDEO_OUT(vout), .VIDEO_OE(voe));
   vocs_core_model core_u (.clk(clk), .rst(rst), .ready(ready), .col_in(m_col),
      .pix_in(m_pix), .want(m_want), .gap(m_gap), .valid(valid), .colours(colours),
      .pixels(pixels), .taken(m_taken));

   task give_verdict;
      if (n_fail == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Hang guard well above the expected run
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         give_verdict();
      end
   end

   task wr(input logic s, input logic [31:0] d);
      @(posedge clk);
      reg_sel <= s;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read answers one cycle after the select
   task rd(input logic s, input logic [31:0] e);
      @(posedge clk);
      reg_sel <= s;
      @(posedge clk);
      #1;
      `CHK(rdata, e)
   endtask

   // Records the next n changes of one byte lane with their cycle stamps
   task watch(input int lane, input int n, output logic [7:0] v [4], output int t [4]);
      int i, g;
      logic [7:0] last;
      i = 0;
      g = 0;
      last = vout[lane*8 +: 8];
      while (i < n && g < 3000)
      begin
         @(posedge clk);
         #1;
         g++;
         if (vout[lane*8 +: 8] !== last)
         begin
            last = vout[lane*8 +: 8];
            v[i] = last;
            t[i] = cyc;
            i++;
         end
      end
      `CHK(i, n)
   endtask

   task regs;
      rd(CFG, 32'h0);
      rd(SCL, 32'h0);
      wr(SCL, 32'hFFFFFFFF);
      wr(CFG, 32'hFFFFFFFF);
      rd(SCL, 32'h000FFFFF);
      rd(CFG, 32'h7F800EFF);
   endtask

   // Each group code once, reserved ones included, with the type code taken from its low two bits
   task groups;
      int i;
      logic [31:0] c, e;
      logic [7:0] m;
      logic [1:0] t;
      for (i = 0; i < 8; i++)
      begin
         t = i[1:0];
         m = (t == 2'h2) ? 8'h0F : (t == 2'h3) ? 8'hF0 : 8'hFF;
         c = {1'b0, t, 1'b0, 16'h0000, i[2:0], 1'b0, m};
         e = (t == 2'h0 || i > 3) ? 32'h0 : {24'h0, m} << (8 * i);
         wr(CFG, c);
         repeat (4) @(posedge clk);
         #1;
         `CHK(voe, e)
      end
   endtask

   // One lit pixel per frame: pixel and frame spacing, LSB first
   task two_colour;
      logic [7:0] v [4];
      int t [4];
      wr(CFG, 32'h200000FF);
      wr(SCL, 32'h00001020); // Frame is 32 pixels of 1 clock
      m_col <= 32'h00008100;
      m_pix <= 32'h00000001;
      m_gap <= 8'h05;
      m_want <= m_taken + 8'h02;
      watch(0, 4, v, t);
      `CHK(v[0], 8'h81)
      `CHK(t[1] - t[0], SYN)
      `CHK(t[2] - t[0], 32 * SYN)
      `CHK(v[2], 8'h81)
   endtask

   // Two-bit pixels on the low half of group 2
   task four_colour;
      logic [7:0] v [4];
      int t [4];
      wr(CFG, 32'h5000040F);
      wr(SCL, 32'h00002020); // Frame is 16 pixels of 2 clocks
      m_col <= 32'h7EC35A00;
      m_pix <= 32'h39393939;
      m_want <= m_taken + 8'h01;
      watch(2, 3, v, t);
      `CHK(voe, 32'h000F0000)
      `CHK({v[0], v[1], v[2]}, 24'h0A030E)
      `CHK(t[2] - t[1], 2 * SYN)
      wr(CFG, 32'h7000040F); // Same pixel, halves swapped
      repeat (2) @(posedge clk);
      #1;
      `CHK(vout, 32'h00070000)
   endtask

   // Synth clock halted: the buffer fills and the core stalls
   task stall;
      logic [7:0] base;
      int g;
      synth_en <= 1'b0;
      wr(CFG, 32'h200000FF);
      base = m_taken;
      m_gap <= 8'h00;
      m_want <= base + 8'h03;
      repeat (20) @(posedge clk);
      #1;
      `CHK(m_taken, base + 8'h02)
      `CHK({ready, valid}, 2'b01)
      synth_en <= 1'b1;
      g = 0;
      while (m_taken !== base + 8'h03 && g < 1000)
      begin
         @(posedge clk);
         g++;
      end
      #1;
      `CHK(m_taken, base + 8'h03)
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      regs();
      groups();
      two_colour();
      four_colour();
      stall();
      give_verdict();
   end
endmodule // vocs_video_gen_tb
